// file: rtl/mqr_flag_bus.sv
// Almost-empty flag bus: direct selection or polled cycling
`timescale 1ns/1ps
`default_nettype none
`include "mqr_regs.svh"

module mqr_flag_bus #(
    parameter int NUM_Q = `MQR_NUM_QUEUES
) (
    // Clock and reset
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_reset,
    // Configuration
    input  wire mqr_pkg::flag_mode_t   i_mode,
    input  wire logic [`MQR_DEV_W-1:0] i_device_id,
    // Status and selection
    input  wire logic [NUM_Q-1:0]      i_ae_status_n,
    input  wire logic                  i_strobe_hit,
    // Flag bus
    output var  logic [NUM_Q-1:0]      o_bus,
    output var  logic                  o_bus_oe,
    output var  logic                  o_sync
);

    logic [`MQR_DEV_W-1:0] poll_q;
    logic                  direct_sel_q;

    //--------------------------------------------------------
    // Decode
    //--------------------------------------------------------
    wire logic polled   = (i_mode == mqr_pkg::FLAG_POLLED);
    wire logic my_slot  = (poll_q == i_device_id);
    wire logic show_now = polled ? my_slot : (direct_sel_q || i_strobe_hit);

    // Poll counter steps every edge in polled mode, no read enable involved
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            poll_q       <= `MQR_ID_RST;
            direct_sel_q <= 1'b0;
        end else begin
            poll_q       <= polled ? poll_q + 1'b1 : `MQR_ID_RST; // [R4] [R15]
            direct_sel_q <= !polled && (direct_sel_q || i_strobe_hit); // [R3] [R13] [R19]
        end
    end

    // Bus drive, enable and sync pulse
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_bus    <= `MQR_FLAGS_RST;
            o_bus_oe <= 1'b0;
            o_sync   <= 1'b0;
        end else begin
            o_bus    <= show_now ? i_ae_status_n : `MQR_FLAGS_RST; // [R3] [R4]
            o_bus_oe <= show_now;
            o_sync   <= polled && (poll_q == `MQR_ID_RST); // [R4]
        end
    end

endmodule

`default_nettype wire

// file: rtl/mqr_out_buffer.sv
// Two-entry output buffer with registered outputs on both sides
`timescale 1ns/1ps
`default_nettype none
`include "mqr_regs.svh"

module mqr_out_buffer #(
    parameter int DATA_W = `MQR_DATA_W
) (
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    // Fill side
    input  wire logic              i_in_valid,
    input  wire logic [DATA_W-1:0] i_in_data,
    output var  logic              o_in_ready,
    // Drain side
    output var  logic              o_out_valid,
    output var  logic [DATA_W-1:0] o_out_data,
    input  wire logic              i_out_ready
);

    //--------------------------------------------------------
    // Handshake decode
    //--------------------------------------------------------
    wire logic take_in  = i_in_valid && o_in_ready;
    wire logic give_out = o_out_valid && i_out_ready;

    logic              spare_valid_q;
    logic [DATA_W-1:0] spare_data_q;

    // Head word moves forward, spare catches a word during a stall
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_out_valid   <= 1'b0;
            spare_valid_q <= 1'b0;
            o_in_ready    <= 1'b1;
        end else begin
            if (!o_out_valid || give_out) begin
                o_out_valid   <= spare_valid_q || take_in;
                spare_valid_q <= spare_valid_q && take_in;
            end else begin
                spare_valid_q <= spare_valid_q || take_in;
            end
            o_in_ready <= !((spare_valid_q || (take_in && o_out_valid)) && !give_out) ||
                          (!spare_valid_q && !take_in);
        end
    end

    // Data path, no reset needed
    always_ff @(posedge i_sys_clk) begin
        if (!o_out_valid || give_out) begin
            o_out_data   <= spare_valid_q ? spare_data_q : i_in_data;
            spare_data_q <= i_in_data;
        end else if (take_in) begin
            spare_data_q <= i_in_data;
        end
    end

endmodule

`default_nettype wire

// file: rtl/mqr_pkg.sv
// Types shared by the multi-queue read port modules
`include "mqr_regs.svh"

package mqr_pkg;

    // Read address split into device select and queue select
    typedef struct packed {
        logic [`MQR_DEV_W-1:0]   dev;
        logic [`MQR_QUEUE_W-1:0] queue;
    } read_addr_t;

    // Queue change sequence, one bit per step up to load, both bits on the return to idle
    typedef enum logic [1:0] {
        SEL_IDLE  = 2'b00,
        SEL_DRAIN = 2'b01,
        SEL_LOAD  = 2'b11
    } sel_stage_t;

    // Flag bus operation fixed at reset
    typedef enum logic {
        FLAG_DIRECT = 1'b0,
        FLAG_POLLED = 1'b1
    } flag_mode_t;

endpackage

// file: rtl/mqr_regs.svh
// Constants of the multi-queue read port: widths, counts and reset values
`ifndef MQR_REGS_SVH
`define MQR_REGS_SVH

//------------------------------------------------------------
// Address layout
//------------------------------------------------------------
`define MQR_ADDR_W      6
`define MQR_QUEUE_LSB   0
`define MQR_QUEUE_W     3
`define MQR_DEV_LSB     3
`define MQR_DEV_W       3

//------------------------------------------------------------
// Sizes and reset values
//------------------------------------------------------------
`define MQR_NUM_QUEUES  8
`define MQR_NUM_DEVS    8
`define MQR_DATA_W      18
`define MQR_QDEPTH      16
`define MQR_AE_LEVEL    2
`define MQR_FLAGS_RST   8'hff
`define MQR_ID_RST      3'h0

`endif

// file: rtl/multiqueue_read_port_select.sv
// Read port of a multi-queue flow-control memory with queue and flag selection
`timescale 1ns/1ps
`default_nettype none
`include "mqr_regs.svh"

//------------------------------------------------------------
// Read port top
//------------------------------------------------------------
// Behaviour
// R1: read enable low reads next selected word
// R2: strobe high latches address as read queue
// R3: direct mode: flag strobe selects shown device
// R4: polled mode steps flag bus, sync on clock
// R5: queue flag and valid flag clock-synchronous
// R6: expansion tokens timed by read clock
// R7: controller keeps read clock free-running
// R8: six-bit address selects queue and device
// R9: low three bits pick one of eight
// R10: high three bits must match device id
// R11: one more old word after select
// R12: first new word on second edge
// R13: flag strobe latches device bits only
// R14: queue select ignores read enable
// R15: flag bus works without read enable
// R16: controller never raises both strobes together
// R17: no select before configuration done
// R18: flag mode captured at master reset
// R19: mismatched id keeps current selections
module multiqueue_read_port_select #(
    parameter int DATA_W   = `MQR_DATA_W,
    parameter int NUM_Q    = `MQR_NUM_QUEUES,
    parameter int QDEPTH   = `MQR_QDEPTH,
    parameter int AE_LEVEL = `MQR_AE_LEVEL
) (
    // Clock and reset
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_reset,
    // Strap and configuration
    input  wire logic [`MQR_DEV_W-1:0]  i_device_id,
    input  wire logic                   i_flag_mode_select,
    // Write side feeding the queues
    input  wire logic                   i_wr_valid,
    input  wire logic [`MQR_QUEUE_W-1:0] i_wr_queue,
    input  wire logic [DATA_W-1:0]      i_wr_data,
    // Read control
    input  wire logic [`MQR_ADDR_W-1:0] i_read_queue_address,
    input  wire logic                   i_read_address_strobe,
    input  wire logic                   i_empty_flag_strobe,
    input  wire logic                   i_read_enable_n,
    input  wire logic                   i_out_ready,
    // Expansion
    input  wire logic                   i_expansion_token_in,
    output logic                        o_expansion_token_out,
    // Read data and flags
    output logic [DATA_W-1:0]           o_read_data,
    output logic                        o_output_valid_flag,
    output logic                        o_almost_empty_flag_n,
    output logic [NUM_Q-1:0]            o_almost_empty_flag_bus,
    output logic                        o_almost_empty_flag_bus_oe,
    output logic                        o_empty_bus_sync,
    output logic [`MQR_QUEUE_W-1:0]     o_read_queue
);

    localparam int PW = $clog2(QDEPTH);

    //--------------------------------------------------------
    // Storage
    //--------------------------------------------------------
    logic [DATA_W-1:0] mem [NUM_Q*QDEPTH];
    logic [PW:0]       wptr_q [NUM_Q];
    logic [PW:0]       rptr_q [NUM_Q];

    // Words held in a queue
    function automatic logic [PW:0] fill(input logic [PW:0] w, input logic [PW:0] r);
        fill = w - r;
    endfunction

    // Flat memory index of a queue slot
    function automatic logic [PW+`MQR_QUEUE_W-1:0] slot(input logic [`MQR_QUEUE_W-1:0] q,
                                                        input logic [PW:0] p);
        slot = {q, p[PW-1:0]};
    endfunction

    //--------------------------------------------------------
    // State
    //--------------------------------------------------------
    mqr_pkg::flag_mode_t   mode_q;
    mqr_pkg::sel_stage_t   stage_q;
    logic [`MQR_QUEUE_W-1:0] cur_q;
    logic [`MQR_QUEUE_W-1:0] pend_q;
    logic                  owner_q;

    //--------------------------------------------------------
    // Address decode
    //--------------------------------------------------------
    mqr_pkg::read_addr_t addr;
    assign addr = i_read_queue_address; // [R8]

    wire logic id_match   = (addr.dev == i_device_id); // [R10]
    wire logic queue_hit  = i_read_address_strobe && id_match; // [R2] [R14] [R19]
    wire logic strobe_hit = i_empty_flag_strobe && id_match; // [R13] [R15]

    // Queue drained this edge: old queue until the load step
    wire logic [`MQR_QUEUE_W-1:0] read_q = (stage_q == mqr_pkg::SEL_LOAD) ? pend_q : cur_q;
    wire logic force_rd   = (stage_q != mqr_pkg::SEL_IDLE); // [R11] [R12]
    wire logic q_nonempty = (fill(wptr_q[read_q], rptr_q[read_q]) != '0);
    wire logic buf_ready;
    wire logic do_read    = owner_q && q_nonempty && buf_ready &&
                            (!i_read_enable_n || force_rd); // [R1]

    // Write side acceptance
    wire logic wr_full = (fill(wptr_q[i_wr_queue], rptr_q[i_wr_queue]) == (PW+1)'(QDEPTH));
    wire logic do_write = i_wr_valid && !wr_full;

    // Almost-empty status of every queue, low when almost empty
    logic [NUM_Q-1:0] ae_status_n;
    always_comb begin
        for (int q = 0; q < NUM_Q; q++) begin
            ae_status_n[q] = (fill(wptr_q[q], rptr_q[q]) > (PW+1)'(AE_LEVEL));
        end
    end

    //--------------------------------------------------------
    // Mode capture and queue selection
    //--------------------------------------------------------
    // Flag mode is sampled only while reset is held
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            mode_q <= mqr_pkg::flag_mode_t'(i_flag_mode_select); // [R18]
        end
    end

    // Queue change sequence: select, drain old, load new
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            stage_q <= mqr_pkg::SEL_IDLE;
            cur_q   <= '0;
            pend_q  <= '0;
        end else begin
            if (queue_hit) begin
                pend_q  <= addr.queue; // [R2] [R9]
                stage_q <= mqr_pkg::SEL_DRAIN; // [R11]
            end else begin
                unique case (stage_q)
                    mqr_pkg::SEL_IDLE: begin
                        stage_q <= mqr_pkg::SEL_IDLE;
                    end
                    mqr_pkg::SEL_DRAIN: begin
                        stage_q <= mqr_pkg::SEL_LOAD;
                    end
                    mqr_pkg::SEL_LOAD: begin
                        stage_q <= mqr_pkg::SEL_IDLE;
                        cur_q   <= pend_q; // [R12]
                    end
                    default: begin
                        stage_q <= mqr_pkg::SEL_IDLE;
                    end
                endcase
            end
        end
    end

    // Read port ownership and expansion token, all on the read clock
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            owner_q               <= 1'b0;
            o_expansion_token_out <= 1'b0;
        end else begin
            if (i_read_address_strobe) begin
                owner_q <= id_match; // [R6]
            end
            o_expansion_token_out <= owner_q && i_read_address_strobe && !id_match
                                     && !i_expansion_token_in; // [R6]
        end
    end

    //--------------------------------------------------------
    // Queue pointers and memory
    //--------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            for (int q = 0; q < NUM_Q; q++) begin
                wptr_q[q] <= '0;
                rptr_q[q] <= '0;
            end
        end else begin
            if (do_write) begin
                wptr_q[i_wr_queue] <= wptr_q[i_wr_queue] + 1'b1;
            end
            if (do_read) begin
                rptr_q[read_q] <= rptr_q[read_q] + 1'b1; // [R1]
            end
        end
    end

    // Word storage
    always_ff @(posedge i_sys_clk) begin
        if (do_write) begin
            mem[slot(i_wr_queue, wptr_q[i_wr_queue])] <= i_wr_data;
        end
    end

    //--------------------------------------------------------
    // Output path and flags
    //--------------------------------------------------------
    // Buffer absorbs a receiver stall without losing a word
    mqr_out_buffer #(
        .DATA_W (DATA_W)
    ) u_out_buffer (
        .i_sys_clk   (i_sys_clk),
        .i_reset     (i_reset),
        .i_in_valid  (do_read),
        .i_in_data   (mem[slot(read_q, rptr_q[read_q])]),
        .o_in_ready  (buf_ready),
        .o_out_valid (o_output_valid_flag), // [R5]
        .o_out_data  (o_read_data),
        .i_out_ready (i_out_ready)
    );

    // Selected queue flag and status
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_almost_empty_flag_n <= 1'b0;
            o_read_queue          <= '0;
        end else begin
            o_almost_empty_flag_n <= ae_status_n[cur_q]; // [R5]
            o_read_queue          <= cur_q;
        end
    end

    // Almost-empty flag bus in direct or polled mode
    mqr_flag_bus #(
        .NUM_Q (NUM_Q)
    ) u_flag_bus (
        .i_sys_clk     (i_sys_clk),
        .i_reset       (i_reset),
        .i_mode        (mode_q),
        .i_device_id   (i_device_id),
        .i_ae_status_n (ae_status_n),
        .i_strobe_hit  (strobe_hit), // [R3]
        .o_bus         (o_almost_empty_flag_bus),
        .o_bus_oe      (o_almost_empty_flag_bus_oe),
        .o_sync        (o_empty_bus_sync) // [R4]
    );

endmodule

`default_nettype wire

// file: verif/mqr_read_port_checker.sv
// Concurrent checks on the multi-queue read port
`timescale 1ns/1ps
`default_nettype none
`include "mqr_regs.svh"
module mqr_read_port_checker #(
    parameter int DATA_W = `MQR_DATA_W,
    parameter int NUM_Q  = `MQR_NUM_QUEUES
) (
    // Clock, reset and straps
    input wire logic                    i_sys_clk,
    input wire logic                    i_reset,
    input wire logic [`MQR_DEV_W-1:0]   i_device_id,
    input wire logic                    i_flag_mode_select,
    // Read control
    input wire logic [`MQR_ADDR_W-1:0]  i_read_queue_address,
    input wire logic                    i_read_address_strobe,
    input wire logic                    i_empty_flag_strobe,
    input wire logic                    i_out_ready,
    // Outputs
    input wire logic                    o_expansion_token_out,
    input wire logic [DATA_W-1:0]       o_read_data,
    input wire logic                    o_output_valid_flag,
    input wire logic [NUM_Q-1:0]        o_almost_empty_flag_bus,
    input wire logic                    o_almost_empty_flag_bus_oe,
    input wire logic                    o_empty_bus_sync,
    input wire logic [`MQR_QUEUE_W-1:0] o_read_queue
);
    logic       polled_q;
    logic [3:0] since_sync_q;
    wire        dev_hit  = i_read_queue_address[5:3] == i_device_id;
    wire        sel_hit  = i_read_address_strobe && dev_hit;
    wire        flag_hit = i_empty_flag_strobe && dev_hit;
    wire [2:0]  sel_queue = i_read_queue_address[2:0];
    // Mode capture and distance from the last sync pulse
    always_ff @(posedge i_sys_clk) begin
        polled_q     <= i_reset ? i_flag_mode_select : polled_q;
        since_sync_q <= (i_reset || o_empty_bus_sync) ? 4'h1 : since_sync_q + 4'h1;
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    property p_sel_queue;
        sel_hit ##1 !i_read_address_strobe [*4] |-> o_read_queue == $past(sel_queue, 4);
    endproperty
    property p_miss_keeps;
        !i_read_address_strobe [*4] ##1 (i_read_address_strobe && !dev_hit) |=> $stable(o_read_queue) [*3];
    endproperty
    property p_sync_period;
        o_empty_bus_sync |=> !o_empty_bus_sync [*7] ##1 o_empty_bus_sync;
    endproperty
    property p_poll_slot;
        polled_q && o_almost_empty_flag_bus_oe |-> since_sync_q == {1'b0, i_device_id};
    endproperty
    property p_poll_pulse;
        polled_q && o_almost_empty_flag_bus_oe |=> !o_almost_empty_flag_bus_oe;
    endproperty
    property p_direct_sel;
        !polled_q && flag_hit |-> ##[1:2] o_almost_empty_flag_bus_oe;
    endproperty
    property p_direct_hold;
        !polled_q && o_almost_empty_flag_bus_oe |=> o_almost_empty_flag_bus_oe;
    endproperty
    property p_bus_idle;
        !o_almost_empty_flag_bus_oe |-> o_almost_empty_flag_bus == {NUM_Q{1'b1}};
    endproperty
    property p_valid_hold;
        o_output_valid_flag && !i_out_ready |=> o_output_valid_flag && $stable(o_read_data);
    endproperty
    property p_token_pulse;
        o_expansion_token_out |=> !o_expansion_token_out;
    endproperty
    a_sel_queue: assert property (p_sel_queue) else $error("read queue not taken");
    a_miss_keeps: assert property (p_miss_keeps) else $error("foreign select moved queue");
    a_sync_period: assert property (p_sync_period) else $error("sync period wrong");
    a_poll_slot: assert property (p_poll_slot) else $error("poll slot wrong");
    a_poll_pulse: assert property (p_poll_pulse) else $error("poll slot too long");
    a_direct_sel: assert property (p_direct_sel) else $error("flag select missed");
    a_direct_hold: assert property (p_direct_hold) else $error("flag select dropped");
    a_bus_idle: assert property (p_bus_idle) else $error("idle flag bus not high");
    a_valid_hold: assert property (p_valid_hold) else $error("word lost in stall");
    a_token_pulse: assert property (p_token_pulse) else $error("token not a pulse");
    c_sel: cover property (sel_hit);
    c_flag: cover property (!polled_q && flag_hit);
    c_poll: cover property (polled_q && o_almost_empty_flag_bus_oe);
    c_stall: cover property (o_output_valid_flag && !i_out_ready);
endmodule
bind multiqueue_read_port_select mqr_read_port_checker #(.DATA_W(DATA_W), .NUM_Q(NUM_Q)) u_checker (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_device_id(i_device_id),
    .i_flag_mode_select(i_flag_mode_select), .i_read_queue_address(i_read_queue_address),
    .i_read_address_strobe(i_read_address_strobe), .i_empty_flag_strobe(i_empty_flag_strobe),
    .i_out_ready(i_out_ready), .o_expansion_token_out(o_expansion_token_out), .o_read_data(o_read_data),
    .o_output_valid_flag(o_output_valid_flag), .o_almost_empty_flag_bus(o_almost_empty_flag_bus),
    .o_almost_empty_flag_bus_oe(o_almost_empty_flag_bus_oe), .o_empty_bus_sync(o_empty_bus_sync),
    .o_read_queue(o_read_queue));
`default_nettype wire

// file: verif/read_ctrl_model.sv
// Read-side controller model: selection strobes, read enable and receiver
`timescale 1ns/1ps
`default_nettype none
module read_ctrl_model (
    // Clock
    input  wire logic       i_sys_clk,
    // Read control
    output var  logic [5:0] o_addr,
    output var  logic       o_addr_stb,
    output var  logic       o_flag_stb,
    output var  logic       o_read_enable_n,
    output var  logic       o_out_ready
);
    initial begin
        o_addr = 6'h00;
        o_addr_stb = 1'b0;
        o_flag_stb = 1'b0;
        o_read_enable_n = 1'b1;
        o_out_ready = 1'b1;
    end
    // One strobe cycle; only one of the two strobes is ever raised
    task automatic select(input logic [5:0] addr, input logic flag);
        @(posedge i_sys_clk);
        o_addr <= addr;
        o_addr_stb <= !flag;
        o_flag_stb <= flag;
        @(posedge i_sys_clk);
        o_addr_stb <= 1'b0;
        o_flag_stb <= 1'b0;
        o_addr <= ~addr; // Released lines show no stale address
    endtask
    // Read enable low for n cycles
    task automatic read(input int n);
        @(posedge i_sys_clk);
        o_read_enable_n <= 1'b0;
        repeat (n) @(posedge i_sys_clk);
        o_read_enable_n <= 1'b1;
    endtask
    // Receiver readiness, level
    task automatic set_ready(input logic rdy);
        @(posedge i_sys_clk);
        o_out_ready <= rdy;
    endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the multi-queue read port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [2:0] DEV = 3'h5;
    logic        i_sys_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        mode = 1'b0;
    logic        wr_valid = 1'b0;
    logic [2:0]  wr_queue = 3'h0;
    logic [17:0] wr_data = 18'h00000;
    wire  logic [5:0]  addr;
    wire  logic        astb, fstb, ren_n, rdy, valid, ae_n, oe, sync, token;
    wire  logic [17:0] rd_data;
    wire  logic [7:0]  bus;
    wire  logic [2:0]  rq;
    logic [17:0] got[$];
    logic [17:0] exp_q[$];
    int          fail_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          n_sync = 0;
    int          n_oe = 0;
    int          n_token = 0;
    logic        tok_in = 1'b0;
    logic [2:0]  dev_id = DEV;
    multiqueue_read_port_select u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_device_id(dev_id),
        .i_flag_mode_select(mode), .i_wr_valid(wr_valid), .i_wr_queue(wr_queue), .i_wr_data(wr_data),
        .i_read_queue_address(addr), .i_read_address_strobe(astb), .i_empty_flag_strobe(fstb),
        .i_read_enable_n(ren_n), .i_out_ready(rdy), .i_expansion_token_in(tok_in),
        .o_expansion_token_out(token), .o_read_data(rd_data), .o_output_valid_flag(valid),
        .o_almost_empty_flag_n(ae_n), .o_almost_empty_flag_bus(bus), .o_almost_empty_flag_bus_oe(oe),
        .o_empty_bus_sync(sync), .o_read_queue(rq));
    read_ctrl_model u_ctl (.i_sys_clk(i_sys_clk), .o_addr(addr), .o_addr_stb(astb), .o_flag_stb(fstb),
        .o_read_enable_n(ren_n), .o_out_ready(rdy));
    // Free-running clock, cycle ceiling and output capture
    always #5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cycles++;
        if (!i_reset && valid === 1'b1 && rdy === 1'b1) got.push_back(rd_data);
        n_token += int'(token === 1'b1);
        if (cycles == 3000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(input string name, input logic [17:0] e, input logic [17:0] a);
        n_compared++;
        if (a !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, e, a);
        end
    endtask
    task automatic chk_stream(input string name, input logic [17:0] base, input int n);
        for (int k = 0; k < n; k++) exp_q.push_back(base + 18'(k));
        chk(name, 18'(n), 18'(got.size()));
        for (int k = 0; k < n && k < got.size(); k++) chk(name, exp_q[k], got[k]);
        exp_q.delete();
        got.delete();
        $display("Done: %s", name);
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask
    task automatic wr(input logic [2:0] q, input logic [17:0] base, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge i_sys_clk);
            wr_valid <= 1'b1;
            wr_queue <= q;
            wr_data <= base + 18'(k);
        end
        @(posedge i_sys_clk);
        wr_valid <= 1'b0;
    endtask
    task automatic do_reset(input logic m, input logic [2:0] id);
        @(posedge i_sys_clk);
        i_reset <= 1'b1;
        mode <= m;
        dev_id <= id;
        repeat (8) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        pause(0);
    endtask
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        do_reset(1'b0, DEV);
        chk("valid", 18'h0, 18'(valid));
        chk("flag bus", 18'h000ff, 18'(bus));
        wr(3'h0, 18'h000a0, 4);
        wr(3'h2, 18'h00200, 5);
        wr(3'h6, 18'h00600, 3);
        u_ctl.select({DEV, 3'h2}, 1'b0);
        pause(6);
        chk("old word", 18'h000a0, got.pop_front());
        chk_stream("first word", 18'h00200, 1);
        chk("read queue", 18'h2, 18'(rq));
        chk("queue flag", 18'h1, 18'(ae_n));
        u_ctl.read(2);
        pause(4);
        chk_stream("reads", 18'h00201, 2);
        u_ctl.select({DEV, 3'h6}, 1'b0);
        pause(6);
        chk(".old word", 18'h00203, got.pop_front());
        chk_stream("new queue", 18'h00600, 1);
        chk("read queue", 18'h6, 18'(rq));
        chk("queue flag", 18'h0, 18'(ae_n));
        u_ctl.read(4);
        pause(4);
        chk_stream("drain", 18'h00601, 2);
        u_ctl.select({3'h2, 3'h1}, 1'b0);
        pause(6);
        chk("foreign queue", 18'h6, 18'(rq));
        chk("token", 18'h1, 18'(n_token));
        wr(3'h1, 18'h00100, 4);
        u_ctl.set_ready(1'b0);
        u_ctl.select({DEV, 3'h1}, 1'b0);
        u_ctl.read(6);
        pause(2);
        chk("stalled word", 18'h00100, rd_data);
        u_ctl.set_ready(1'b1);
        u_ctl.read(6);
        pause(6);
        chk_stream("stall", 18'h00100, 4);
        u_ctl.select({3'h2, 3'h7}, 1'b1);
        pause(3);
        chk("foreign flags", 18'h0, 18'(oe));
        u_ctl.select({DEV, 3'h7}, 1'b1);
        pause(3);
        chk("flag oe", 18'h1, 18'(oe));
        chk("flag bus", 18'h00001, 18'(bus));
        @(posedge i_sys_clk) tok_in <= 1'b1;
        u_ctl.select({3'h2, 3'h3}, 1'b0);
        pause(3);
        chk("suppressed token", 18'h1, 18'(n_token));
        $display("Done: direct flags");
        do_reset(1'b1, 3'h2);
        repeat (16) begin
            n_sync += int'(sync === 1'b1);
            n_oe += int'(oe === 1'b1);
            pause(0);
        end
        chk("sync pulses", 18'h2, 18'(n_sync));
        chk("poll slots", 18'h2, 18'(n_oe));
        $display("Done: polled flags");
        end_of_test();
    end
endmodule
`default_nettype wire
